// *** rtl/ppcr_pkg.sv ***
// package: register map, field layouts and reset values of the pixel pll and phase bank
package ppcr_pkg;

  // register indexes; the bus byte address is four times the index
  localparam logic [5:0] IDX_INPUT_CONTROL   = 6'h00;
  localparam logic [5:0] IDX_LOOP_CONTROL    = 6'h01;
  localparam logic [5:0] IDX_FEEDBACK_LOW    = 6'h02;
  localparam logic [5:0] IDX_FEEDBACK_HIGH   = 6'h03;
  localparam logic [5:0] IDX_PHASE_OFFSET    = 6'h04;
  localparam logic [5:0] IDX_PHASE_RES       = 6'h05;
  localparam logic [5:0] IDX_OUTPUT_ENABLES  = 6'h06;
  localparam logic [5:0] IDX_OSCILLATOR_DIVIDER     = 6'h07;
  localparam logic [5:0] IDX_LOOP_FILTER     = 6'h08;
  localparam logic [5:0] IDX_RESTART         = 6'h0A;
  localparam logic [5:0] IDX_STATUS          = 6'h0B;

  // position of the index inside the byte address
  localparam int ADDR_LSB = 2;
  localparam int ADDR_W   = 8;

  // storable bits; reserved bits are never stored and read zero
  localparam logic [7:0] MASK_INPUT_CONTROL  = 8'hFF;
  localparam logic [7:0] MASK_LOOP_CONTROL   = 8'h37;
  localparam logic [7:0] MASK_FEEDBACK_LOW   = 8'hFF;
  localparam logic [7:0] MASK_FEEDBACK_HIGH  = 8'h0F;
  localparam logic [7:0] MASK_PHASE_OFFSET   = 8'h3F;
  localparam logic [7:0] MASK_PHASE_RES      = 8'h03;
  localparam logic [7:0] MASK_OUTPUT_ENABLES = 8'h7C;
  localparam logic [7:0] MASK_OSCILLATOR_DIVIDER    = 8'hFF;
  localparam logic [7:0] MASK_LOOP_FILTER    = 8'hFF;

  // values after reset
  localparam logic [7:0] RST_INPUT_CONTROL   = 8'h21;
  localparam logic [7:0] RST_LOOP_CONTROL    = 8'h00;
  localparam logic [7:0] RST_FEEDBACK_LOW    = 8'hFF;
  localparam logic [7:0] RST_FEEDBACK_HIGH   = 8'h00;
  localparam logic [7:0] RST_PHASE_OFFSET    = 8'h00;
  localparam logic [7:0] RST_PHASE_RES       = 8'h00;
  localparam logic [7:0] RST_OUTPUT_ENABLES  = 8'h00;
  localparam logic [7:0] RST_OSCILLATOR_DIVIDER     = 8'h00;
  localparam logic [7:0] RST_LOOP_FILTER     = 8'hFF;

  // restart register trigger nibbles
  localparam logic [3:0] PLL_RESTART_CODE    = 4'h5;
  localparam logic [3:0] PHASE_RESTART_CODE  = 4'hA;

  // status register bit positions
  localparam int STAT_PLL_PENDING   = 0;
  localparam int STAT_PHASE_PENDING = 1;

  // input control layout, msb first
  typedef struct packed {
    logic [1:0] hsync_schmitt_sel;
    logic       input_source_sel;
    logic       feedback_load_sel;
    logic       feedback_invert;
    logic       reference_invert;
    logic       detector_gate_polarity;
    logic       phase_detector_enable;
  } ppcr_input_control_t;

  // loop control layout
  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic [1:0] post_scaler_divider;
    logic       rsvd_mid;
    logic [2:0] phase_detector_gain;
  } ppcr_loop_control_t;

  // output enables layout
  typedef struct packed {
    logic       rsvd_hi;
    logic       converter_clock_enable;
    logic       capture_clock_out_enable;
    logic       delayed_sync_out_enable;
    logic       func_source_sel;
    logic       func_delay_sel;
    logic [1:0] rsvd_lo;
  } ppcr_output_enables_t;

  // loop filter selection layout
  typedef struct packed {
    logic       shunt_cap_sel;
    logic [2:0] resistor_sel;
    logic [2:0] capacitor_sel;
    logic       filter_type_sel;
  } ppcr_loop_filter_t;

endpackage

// *** rtl/ppcr_shadow_reg.sv ***
// holding register plus working copy; the working copy loads from it on a restart strobe
`timescale 1ns/100ps
`default_nettype none
module ppcr_shadow_reg #(
  parameter int               WIDTH       = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // host side
  input  wire logic             write_en_in,
  input  wire logic [WIDTH-1:0] write_data_in,
  input  wire logic             load_in,
  // values
  output logic      [WIDTH-1:0] hold_out,
  output logic      [WIDTH-1:0] work_out
);

  logic [WIDTH-1:0] hold_q;  // last value software wrote
  logic [WIDTH-1:0] hold_d;
  logic [WIDTH-1:0] work_q;  // value the analog side uses
  logic [WIDTH-1:0] work_d;

  // a write in the load cycle is not yet seen by the working copy
  always_comb begin
    hold_d = write_en_in ? write_data_in : hold_q;
    work_d = load_in ? hold_q : work_q;
  end

  // registers
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      hold_q <= RESET_VALUE;
      work_q <= RESET_VALUE;
    end else begin
      hold_q <= hold_d;
      work_q <= work_d;
    end
  end

  assign hold_out = hold_q;
  assign work_out = work_q;

endmodule
`default_nettype wire

// *** rtl/ppcr_avalon_ack.sv ***
// avalon-mm handshake: one wait state, then a single commit cycle
`timescale 1ns/100ps
`default_nettype none
module ppcr_avalon_ack (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  // request from the master
  input  wire logic read_in,
  input  wire logic write_in,
  // handshake
  output logic      waitrequest_out,
  output logic      sample_out,
  output logic      commit_out
);

  logic wait_q;  // high while idle, low for the answer cycle
  logic wait_d;
  logic req;

  // a request is held until it sees waitrequest low
  always_comb begin
    req    = read_in | write_in;
    wait_d = ~(req & wait_q);
  end

  // registers
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= wait_d;
    end
  end

  assign waitrequest_out = wait_q;
  assign sample_out      = req & wait_q;
  assign commit_out      = req & ~wait_q;

endmodule
`default_nettype wire

// *** rtl/ppcr_regs.sv ***
// pixel pll and phase adjuster control register bank behind an avalon-mm slave
`timescale 1ns/100ps
`default_nettype none
module ppcr_regs (
  // clock and reset
  input  wire logic                           SYS_CLK_IN,
  input  wire logic                           RESET_IN,
  // avalon-mm slave
  input  wire logic [ppcr_pkg::ADDR_W-1:0]    AVS_ADDRESS_IN,
  input  wire logic                           AVS_READ_IN,
  input  wire logic                           AVS_WRITE_IN,
  input  wire logic [31:0]                    AVS_WRITEDATA_IN,
  input  wire logic [3:0]                     AVS_BYTEENABLE_IN,
  output logic      [31:0]                    AVS_READDATA_OUT,
  output logic                                AVS_WAITREQUEST_OUT,
  // pll input stage controls
  output var ppcr_pkg::ppcr_input_control_t   INPUT_CONTROL_OUT,
  // pll loop working values
  output var ppcr_pkg::ppcr_loop_control_t    LOOP_CONTROL_OUT,
  output logic      [11:0]                    FEEDBACK_DIVIDER_OUT,
  // dynamic phase adjuster
  output logic      [5:0]                     PHASE_OFFSET_VALUE_OUT,
  output logic      [1:0]                     PHASE_RESOLUTION_SELECT_OUT,
  // output gating, function select, oscillator divider and loop filter
  output var ppcr_pkg::ppcr_output_enables_t  OUTPUT_ENABLES_OUT,
  output logic      [7:0]                     OSCILLATOR_DIVIDER_VALUE_OUT,
  output var ppcr_pkg::ppcr_loop_filter_t     LOOP_FILTER_OUT,
  // restart strobes
  output logic                                PLL_RESTART_OUT,
  output logic                                PHASE_ADJUST_RESTART_OUT
);

  // helpers
  // masking and index match serve every stored register,
  // so each lives in one function

  // keep only the storable bits of a written byte
  function automatic logic [7:0] keep_bits(input logic [7:0] data,
                                           input logic [7:0] mask);
    return data & mask;
  endfunction

  // true when a committed write lands on the given index
  function automatic logic write_hit(input logic       wr,
                                     input logic [5:0] idx,
                                     input logic [5:0] target);
    return wr & (idx == target);
  endfunction

  // bus handshake
  // one fixed wait state; the answer edge is the only
  // edge at which a write lands or read data is taken

  logic       bus_wait;    // waitrequest from the handshake flop
  logic       bus_sample;  // request seen, answer prepared this edge
  logic       bus_commit;  // answer cycle, write takes effect this edge
  logic [5:0] idx;         // register index from the byte address
  logic [7:0] wbyte;       // only the low lane carries data
  logic       wr_commit;   // committed write with lane 0 enabled

  // fixed one wait state keeps read data a plain registered mux
  ppcr_avalon_ack u_ack (
    .clk_in          (SYS_CLK_IN),
    .reset_in        (RESET_IN),
    .read_in         (AVS_READ_IN),
    .write_in        (AVS_WRITE_IN),
    .waitrequest_out (bus_wait),
    .sample_out      (bus_sample),
    .commit_out      (bus_commit)
  );

  // address decode and write qualification
  always_comb begin
    idx       = AVS_ADDRESS_IN[ppcr_pkg::ADDR_W-1:ppcr_pkg::ADDR_LSB];
    wbyte     = AVS_WRITEDATA_IN[7:0];
    // a write without lane 0 enabled changes nothing
    wr_commit = bus_commit & AVS_WRITE_IN & AVS_BYTEENABLE_IN[0];
  end

  // restart register
  // write only: the byte is decoded and dropped,
  // nothing of it is kept for read-back

  logic wr_restart;   // committed write to the restart index
  logic pll_load;     // transfer pll holding values now
  logic phase_load;   // transfer resolution holding value now

  // each nibble is checked on its own; 5Ah fires both
  always_comb begin
    wr_restart = write_hit(wr_commit, idx, ppcr_pkg::IDX_RESTART);
    pll_load   = wr_restart
               & (wbyte[7:4] == ppcr_pkg::PLL_RESTART_CODE);
    phase_load = wr_restart
               & (wbyte[3:0] == ppcr_pkg::PHASE_RESTART_CODE);
  end

  logic pll_restart_q;    // one-cycle pll restart strobe
  logic pll_restart_d;
  logic phase_restart_q;  // one-cycle phase adjuster restart strobe
  logic phase_restart_d;

  // strobes rise in the same cycle the working copies change
  always_comb begin
    pll_restart_d   = pll_load;
    phase_restart_d = phase_load;
  end

  // restart strobe registers
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pll_restart_q   <= 1'b0;
      phase_restart_q <= 1'b0;
    end else begin
      pll_restart_q   <= pll_restart_d;
      phase_restart_q <= phase_restart_d;
    end
  end

  // double-buffered registers
  // host writes land in holding copies; the pll and the
  // adjuster keep their working copies until a restart

  logic [7:0] loop_hold;   // loop control as software wrote it
  logic [7:0] loop_work;   // loop control the pll runs on
  logic [7:0] fbl_hold;    // feedback divider low byte, holding
  logic [7:0] fbl_work;    // feedback divider low byte, working
  logic [7:0] fbh_hold;    // feedback divider high nibble, holding
  logic [7:0] fbh_work;    // feedback divider high nibble, working
  logic [7:0] res_hold;    // phase resolution, holding
  logic [7:0] res_work;    // phase resolution, working

  // loop control: post scaler and detector gain
  ppcr_shadow_reg #(
    .WIDTH       (8),
    .RESET_VALUE (ppcr_pkg::RST_LOOP_CONTROL)
  ) u_loop (
    .clk_in        (SYS_CLK_IN),
    .reset_in      (RESET_IN),
    .write_en_in   (write_hit(wr_commit, idx, ppcr_pkg::IDX_LOOP_CONTROL)),
    .write_data_in (keep_bits(wbyte, ppcr_pkg::MASK_LOOP_CONTROL)),
    .load_in       (pll_load),
    .hold_out      (loop_hold),
    .work_out      (loop_work)
  );

  // feedback divider bits 7-0
  ppcr_shadow_reg #(
    .WIDTH       (8),
    .RESET_VALUE (ppcr_pkg::RST_FEEDBACK_LOW)
  ) u_fb_low (
    .clk_in        (SYS_CLK_IN),
    .reset_in      (RESET_IN),
    .write_en_in   (write_hit(wr_commit, idx, ppcr_pkg::IDX_FEEDBACK_LOW)),
    .write_data_in (keep_bits(wbyte, ppcr_pkg::MASK_FEEDBACK_LOW)),
    .load_in       (pll_load),
    .hold_out      (fbl_hold),
    .work_out      (fbl_work)
  );

  // feedback divider bits 11-8
  ppcr_shadow_reg #(
    .WIDTH       (8),
    .RESET_VALUE (ppcr_pkg::RST_FEEDBACK_HIGH)
  ) u_fb_high (
    .clk_in        (SYS_CLK_IN),
    .reset_in      (RESET_IN),
    .write_en_in   (write_hit(wr_commit, idx, ppcr_pkg::IDX_FEEDBACK_HIGH)),
    .write_data_in (keep_bits(wbyte, ppcr_pkg::MASK_FEEDBACK_HIGH)),
    .load_in       (pll_load),
    .hold_out      (fbh_hold),
    .work_out      (fbh_work)
  );

  // phase resolution, loaded only by the phase restart
  ppcr_shadow_reg #(
    .WIDTH       (8),
    .RESET_VALUE (ppcr_pkg::RST_PHASE_RES)
  ) u_res (
    .clk_in        (SYS_CLK_IN),
    .reset_in      (RESET_IN),
    .write_en_in   (write_hit(wr_commit, idx, ppcr_pkg::IDX_PHASE_RES)),
    .write_data_in (keep_bits(wbyte, ppcr_pkg::MASK_PHASE_RES)),
    .load_in       (phase_load),
    .hold_out      (res_hold),
    .work_out      (res_work)
  );

  // directly written registers
  // these act on the edge the write lands
  // and have no holding copy

  logic [7:0] inctl_q;   // input control
  logic [7:0] inctl_d;
  logic [7:0] offs_q;    // phase offset, takes effect at once
  logic [7:0] offs_d;
  logic [7:0] oen_q;     // output enables and function select
  logic [7:0] oen_d;
  logic [7:0] osc_q;     // oscillator divider
  logic [7:0] osc_d;
  logic [7:0] filt_q;    // loop filter component select
  logic [7:0] filt_d;

  // next values; reserved bits stay zero whatever the host writes
  always_comb begin
    inctl_d = inctl_q;
    offs_d  = offs_q;
    oen_d   = oen_q;
    osc_d   = osc_q;
    filt_d  = filt_q;
    if (write_hit(wr_commit, idx, ppcr_pkg::IDX_INPUT_CONTROL)) begin
      // schmitt, source, load, polarities and enable
      inctl_d = keep_bits(wbyte, ppcr_pkg::MASK_INPUT_CONTROL);
    end
    if (write_hit(wr_commit, idx, ppcr_pkg::IDX_PHASE_OFFSET)) begin
      // no holding copy: the adjuster follows the write
      offs_d = keep_bits(wbyte, ppcr_pkg::MASK_PHASE_OFFSET);
    end
    if (write_hit(wr_commit, idx, ppcr_pkg::IDX_OUTPUT_ENABLES)) begin
      // bits 1-0 and 7 are dropped, which protects reserved defaults
      oen_d = keep_bits(wbyte, ppcr_pkg::MASK_OUTPUT_ENABLES);
    end
    if (write_hit(wr_commit, idx, ppcr_pkg::IDX_OSCILLATOR_DIVIDER)) begin
      // whole byte is the divider value
      osc_d = keep_bits(wbyte, ppcr_pkg::MASK_OSCILLATOR_DIVIDER);
    end
    if (write_hit(wr_commit, idx, ppcr_pkg::IDX_LOOP_FILTER)) begin
      // shunt, resistor, capacitor and filter type
      filt_d = keep_bits(wbyte, ppcr_pkg::MASK_LOOP_FILTER);
    end
  end

  // direct register flops with their documented reset values
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      inctl_q <= ppcr_pkg::RST_INPUT_CONTROL;
      offs_q  <= ppcr_pkg::RST_PHASE_OFFSET;
      oen_q   <= ppcr_pkg::RST_OUTPUT_ENABLES;
      osc_q   <= ppcr_pkg::RST_OSCILLATOR_DIVIDER;
      filt_q  <= ppcr_pkg::RST_LOOP_FILTER;
    end else begin
      inctl_q <= inctl_d;
      offs_q  <= offs_d;
      oen_q   <= oen_d;
      osc_q   <= osc_d;
      filt_q  <= filt_d;
    end
  end

  // status and read-back
  // status is this block's own convenience, read only;
  // writes to its index are ignored

  logic [7:0] status;   // pending transfers, block's own state
  logic [7:0] rbyte;    // selected register byte

  // pending means a holding value differs from its working copy
  always_comb begin
    status = 8'h00;
    status[ppcr_pkg::STAT_PLL_PENDING]   = (loop_hold != loop_work)
                                         | (fbl_hold != fbl_work)
                                         | (fbh_hold != fbh_work);
    status[ppcr_pkg::STAT_PHASE_PENDING] = (res_hold != res_work);
  end

  // double-buffered registers read back the holding value
  always_comb begin
    case (idx)
      ppcr_pkg::IDX_INPUT_CONTROL:  rbyte = inctl_q;
      ppcr_pkg::IDX_LOOP_CONTROL:   rbyte = loop_hold;
      ppcr_pkg::IDX_FEEDBACK_LOW:   rbyte = fbl_hold;
      ppcr_pkg::IDX_FEEDBACK_HIGH:  rbyte = fbh_hold;
      ppcr_pkg::IDX_PHASE_OFFSET:   rbyte = offs_q;
      ppcr_pkg::IDX_PHASE_RES:      rbyte = res_hold;
      ppcr_pkg::IDX_OUTPUT_ENABLES: rbyte = oen_q;
      ppcr_pkg::IDX_OSCILLATOR_DIVIDER:    rbyte = osc_q;
      ppcr_pkg::IDX_LOOP_FILTER:    rbyte = filt_q;
      ppcr_pkg::IDX_STATUS:         rbyte = status;
      // restart register stores nothing and reads zero
      ppcr_pkg::IDX_RESTART:        rbyte = 8'h00;
      // unmapped indexes read zero
      default:                      rbyte = 8'h00;
    endcase
  end

  logic [31:0] rdata_q;  // read data, stands through the answer cycle
  logic [31:0] rdata_d;

  // captured on the edge the request is first seen
  always_comb begin
    rdata_d = rdata_q;
    if (bus_sample & AVS_READ_IN) begin
      rdata_d = {24'h000000, rbyte};
    end
  end

  // read data register
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // outputs, all straight from flops
  // no logic after the registers, so the analog side
  // never sees a decode glitch

  assign AVS_READDATA_OUT             = rdata_q;
  assign AVS_WAITREQUEST_OUT          = bus_wait;
  assign INPUT_CONTROL_OUT            = ppcr_pkg::ppcr_input_control_t'(inctl_q);
  assign LOOP_CONTROL_OUT             = ppcr_pkg::ppcr_loop_control_t'(loop_work);
  assign FEEDBACK_DIVIDER_OUT         = {fbh_work[3:0], fbl_work};
  assign PHASE_OFFSET_VALUE_OUT       = offs_q[5:0];
  assign PHASE_RESOLUTION_SELECT_OUT  = res_work[1:0];
  assign OUTPUT_ENABLES_OUT           = ppcr_pkg::ppcr_output_enables_t'(oen_q);
  assign OSCILLATOR_DIVIDER_VALUE_OUT = osc_q;
  assign LOOP_FILTER_OUT              = ppcr_pkg::ppcr_loop_filter_t'(filt_q);
  assign PLL_RESTART_OUT              = pll_restart_q;
  assign PHASE_ADJUST_RESTART_OUT     = phase_restart_q;

endmodule
`default_nettype wire

// *** tb/ppcr_regs_asserts.sv ***
// checker: bus handshake, restart strobes and buffered working values
`timescale 1ns/100ps
`default_nettype none
module ppcr_regs_asserts (
  // clock and reset
  input  wire logic                          SYS_CLK_IN,
  input  wire logic                          RESET_IN,
  // bus side
  input  wire logic [ppcr_pkg::ADDR_W-1:0]   AVS_ADDRESS_IN,
  input  wire logic                          AVS_READ_IN,
  input  wire logic                          AVS_WRITE_IN,
  input  wire logic [31:0]                   AVS_WRITEDATA_IN,
  input  wire logic [3:0]                    AVS_BYTEENABLE_IN,
  input  wire logic                          AVS_WAITREQUEST_OUT,
  // watched outputs
  input  wire ppcr_pkg::ppcr_loop_control_t  LOOP_CONTROL_OUT,
  input  wire logic [11:0]                   FEEDBACK_DIVIDER_OUT,
  input  wire logic [5:0]                    PHASE_OFFSET_VALUE_OUT,
  input  wire logic [1:0]                    PHASE_RESOLUTION_SELECT_OUT,
  input  wire logic                          PLL_RESTART_OUT,
  input  wire logic                          PHASE_ADJUST_RESTART_OUT
);
  // a write lands on the edge where waitrequest is seen low
  wire logic       commit = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_BYTEENABLE_IN[0];
  wire logic [5:0] idx    = AVS_ADDRESS_IN[7:2];
  wire logic       rst_w  = commit && idx == ppcr_pkg::IDX_RESTART;
  wire logic       pll_w  = rst_w && AVS_WRITEDATA_IN[7:4] == ppcr_pkg::PLL_RESTART_CODE;
  wire logic       pha_w  = rst_w && AVS_WRITEDATA_IN[3:0] == ppcr_pkg::PHASE_RESTART_CODE;
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);
  // strobe is high for exactly one cycle
  sequence one_pulse_s(s);
    s ##1 !s;
  endsequence
  wait_taken_a: // handshake
    assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
    else $error("waitrequest did not drop after a request");
  wait_single_a: // handshake
    assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("waitrequest low for more than one cycle");
  pll_pulse_a:
    assert property (pll_w |=> one_pulse_s(PLL_RESTART_OUT)) else $error("no pll restart pulse");
  pll_cause_a:
    assert property (PLL_RESTART_OUT |-> $past(pll_w)) else $error("pll restart without its code");
  phase_pulse_a:
    assert property (pha_w |=> one_pulse_s(PHASE_ADJUST_RESTART_OUT)) else $error("no phase pulse");
  phase_cause_a:
    assert property (PHASE_ADJUST_RESTART_OUT |-> $past(pha_w)) else $error("phase pulse uncaused");
  loop_hold_a:
    assert property (!$stable({LOOP_CONTROL_OUT, FEEDBACK_DIVIDER_OUT}) |-> PLL_RESTART_OUT)
    else $error("pll working value moved without restart");
  res_hold_a:
    assert property (!$stable(PHASE_RESOLUTION_SELECT_OUT) |-> PHASE_ADJUST_RESTART_OUT)
    else $error("resolution moved without restart");
  offset_direct_a:
    assert property (commit && idx == ppcr_pkg::IDX_PHASE_OFFSET
                     |=> PHASE_OFFSET_VALUE_OUT == $past(AVS_WRITEDATA_IN[5:0]))
    else $error("phase offset not written directly");
endmodule
bind ppcr_regs ppcr_regs_asserts ppcr_regs_asserts_i (.SYS_CLK_IN, .RESET_IN, .AVS_ADDRESS_IN,
  .AVS_READ_IN, .AVS_WRITE_IN, .AVS_WRITEDATA_IN, .AVS_BYTEENABLE_IN, .AVS_WAITREQUEST_OUT,
  .LOOP_CONTROL_OUT, .FEEDBACK_DIVIDER_OUT, .PHASE_OFFSET_VALUE_OUT,
  .PHASE_RESOLUTION_SELECT_OUT, .PLL_RESTART_OUT, .PHASE_ADJUST_RESTART_OUT);
`default_nettype wire

// *** tb/ppcr_regs_bench.sv ***
// testbench: register bank driven over avalon-mm with expected values
`timescale 1ns/100ps
`default_nettype none
module ppcr_regs_bench;
  // reset values and storable bits, index 00h to 08h
  localparam logic [7:0] RV [9] = '{8'h21, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
  localparam logic [7:0] MK [9] = '{8'hFF, 8'h37, 8'hFF, 8'h0F, 8'h3F, 8'h03, 8'h7C, 8'hFF, 8'hFF};
  logic                            clk = 1'b0;
  logic                            rst = 1'b1;
  logic [7:0]                      addr = 8'h00;
  logic                            rd = 1'b0;
  logic                            wr = 1'b0;
  logic [31:0]                     wdata = 32'h00000000;
  logic [3:0]                      be = 4'hF;
  logic [31:0]                     rdata;
  logic [31:0]                     got;
  logic                            wreq;
  ppcr_pkg::ppcr_input_control_t   ic;
  ppcr_pkg::ppcr_loop_control_t    lc;
  ppcr_pkg::ppcr_output_enables_t  oe;
  ppcr_pkg::ppcr_loop_filter_t     lf;
  logic [11:0]                     fb;
  logic [5:0]                      ofs;
  logic [1:0]                      res;
  logic [7:0]                      osc;
  int                              n_fail = 0;
  int                              n_tests = 0;
  int                              cyc = 0;
  ppcr_regs ppcr_regs_i (.SYS_CLK_IN(clk), .RESET_IN(rst), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq), .INPUT_CONTROL_OUT(ic),
    .LOOP_CONTROL_OUT(lc), .FEEDBACK_DIVIDER_OUT(fb), .PHASE_OFFSET_VALUE_OUT(ofs),
    .PHASE_RESOLUTION_SELECT_OUT(res), .OUTPUT_ENABLES_OUT(oe),
    .OSCILLATOR_DIVIDER_VALUE_OUT(osc), .LOOP_FILTER_OUT(lf), .PLL_RESTART_OUT(),
    .PHASE_ADJUST_RESTART_OUT());
  // free running clock
  always #5 clk = ~clk;
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      n_fail++;
    end
  endtask
  // one bus cycle; request held until waitrequest is seen low
  task automatic acc(input logic w, input logic [5:0] i, input logic [7:0] d);
    addr <= {i, 2'b00};
    rd <= !w;
    wr <= w;
    wdata <= {24'h000000, d};
    // no cycle count assumed; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // one idle edge so the next request never reassigns in this step
    @(posedge clk);
  endtask
  task automatic wrt(input logic [5:0] i, input logic [7:0] d);
    acc(1'b1, i, d);
  endtask
  task automatic rdc(input logic [5:0] i, input logic [7:0] e);
    acc(1'b0, i, 8'h00);
    chk(got, {24'h000000, e});
  endtask
  // verdict, reached from the main sequence or the watchdog
  task automatic conclude();
    $display("counts: %0d compared, %0d mismatched", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog; a full run needs under 150 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 9; i++) rdc(i[5:0], RV[i]);
    chk(32'(ic), 32'h21);
    chk(32'(lf), 32'hFF);
    chk(32'(fb), 32'h0FF);
    chk(32'({oe, osc, ofs, res}), 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 9; i++) wrt(i[5:0], MK[i]);
    for (int i = 0; i < 9; i++) rdc(i[5:0], MK[i]);
    chk(32'(ic), 32'hFF);
    chk(32'(oe), 32'h7C);
    chk(32'({ofs, osc}), 32'h3FFF);
    chk(32'({lc, fb, res}), 32'h003FC);
    rdc(6'h0B, 8'h03);
    $display("test all ones done");
    wrt(6'h0A, 8'h50);
    chk(32'({lc, fb, res}), 32'hDFFFC);
    rdc(6'h0B, 8'h02);
    wrt(6'h0A, 8'h0A);
    chk(32'(res), 32'h3);
    wrt(6'h01, 8'h00);
    wrt(6'h05, 8'h00);
    wrt(6'h0A, 8'hA5);
    chk(32'({lc, res}), 32'h37 * 4 + 3);
    rdc(6'h0B, 8'h03);
    rdc(6'h0A, 8'h00);
    wrt(6'h02, 8'hA5);
    wrt(6'h03, 8'h0C);
    wrt(6'h0A, 8'h5A);
    chk(32'({lc, fb, res}), 32'h03294);
    rdc(6'h0B, 8'h00);
    $display("test restart codes done");
    be <= 4'h0;
    wrt(6'h07, 8'h5A);
    be <= 4'hF;
    rdc(6'h07, 8'hFF);
    wrt(6'h09, 8'h00);
    rdc(6'h09, 8'h00);
    // two edges in reset so no sampled-value check straddles the jump
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(6'h00, 8'h21);
    chk(32'(lf), 32'hFF);
    $display("test refusals and second reset done");
    conclude();
  end
endmodule
`default_nettype wire
